// >>> core/crc_pkg.sv
// Summary of operation
// - result bit 6 of control, read-only
// - three output modes drive pin two unsynchronised
// - direction bit 2 clear enables pin two driver
// - analog-input pins read zero in port reads
// - ladder reference used in four modes
// - 16 levels per range, range bit one selects low
// - level code selects ladder tap per range
// - enabled comparator and reference run through sleep
// - comparator interrupt wakes device from sleep
// - wake leaves both control registers unchanged
// - reset loads mode 000 and reference off
// - reference bit 7 powers ladder on
// - reference bits 6 and 4 read zero
// - range bit 5, level code bits 3-0
// - change flag set on output change
// - only software clears flag; writing one sets
// - irq needs change, peripheral, global enables
// - mismatch re-sets flag until control access
// - change during control read may be missed
// - result is positive above negative, invert flips
package crc_pkg;
   localparam logic [7:0] OFS_INTCTL = 8'h0b;
   localparam logic [7:0] OFS_PFLAG  = 8'h0c;
   localparam logic [7:0] OFS_CMPCTL = 8'h19;
   localparam logic [7:0] OFS_PINDIR = 8'h85;
   localparam logic [7:0] OFS_PENA   = 8'h8c;
   localparam logic [7:0] OFS_REFCTL = 8'h99;
   localparam logic [7:0] OFS_PORT   = 8'h05;
   localparam logic [7:0] OFS_ANSEL  = 8'h9f;
   localparam logic [7:0] RST_PINDIR = 8'h3f;
   localparam logic [7:0] RST_ANSEL  = 8'h0f;
   localparam logic [7:0] RST_ZERO   = 8'h00;
   localparam int BIT_RESULT = 6;
   localparam int BIT_INVERT = 4;
   localparam int BIT_INSW   = 3;
   localparam int BIT_CHG    = 3;
   localparam int BIT_PERIPH_EN = 6;
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_REFEN  = 7;
   localparam int BIT_RANGE  = 5;
   localparam int BIT_PIN2   = 2;
   localparam logic [7:0] REF_MASK  = 8'ha0 | 8'h0f;
   localparam logic [7:0] CMP_MASK  = 8'h1f;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [2:0] MODE_OFF   = 3'h7;
   typedef struct packed {
      logic [2:0] mode;
      logic       input_switch;
      logic       invert;
      logic       ref_enable;
      logic       ref_range_low;
      logic [3:0] ref_level;
      logic       comparator_on;
      logic       use_reference;
      logic       pin2_output;
      logic       pin2_oe;
   } crc_analog_s;
endpackage : crc_pkg

// >>> core/crc_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none
// mode decode: purely combinational; output modes bypass the clock
module crc_mode_decode
   import crc_pkg::*;
(
   input  wire logic [2:0] mode,
   input  wire logic       pin2_dir,
   output logic            comparator_on,
   output logic            use_reference,
   output logic            pin2_output,
   output logic            pin2_oe
);
   always_comb
   begin
      comparator_on = (mode != MODE_RESET) && (mode != MODE_OFF);
      // modes 010,011,100,110 use the ladder
      use_reference = (mode == 3'h2) || (mode == 3'h3) || (mode == 3'h4)
                      || (mode == 3'h6);
      // modes 001,011,101 drive the result onto pin two
      pin2_output = (mode == 3'h1) || (mode == 3'h3) || (mode == 3'h5);
      pin2_oe = pin2_output && !pin2_dir;
   end
endmodule : crc_mode_decode
`default_nettype wire

// >>> core/crc_top.sv
`timescale 1ns/1ps
`default_nettype none
module crc_top
   import crc_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              analog_compare,
   input  wire logic [5:0]        port_pins_in,
   input  wire logic              sleep_active,
   output var crc_pkg::crc_analog_s analog_ctl,
   output logic                   comparator_result_bit,
   output logic                   irq_request,
   output logic                   wake_request
);
   import crc_pkg::*;

   typedef struct packed {
      logic [7:0]  intctl;
      logic [7:0]  pflag;
      logic [7:0]  cmpctl;
      logic [7:0]  pindir;
      logic [7:0]  pena;
      logic [7:0]  refctl;
      logic [7:0]  ansel;
      logic        result_sync;
      logic        result;
      logic        latched;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        irq;
      logic        wake;
      crc_analog_s actl;
   } crc_state_s;

   crc_state_s st;
   crc_state_s next_st;
   logic       dec_on;
   logic       dec_ref;
   logic       dec_pin2;
   logic       dec_oe;
   logic       live;
   logic       setup;
   logic       access;
   logic       is_cmp;
   logic [7:0] rd8;
   logic [7:0] port_rd;
   logic [7:0] addr8;

   crc_mode_decode u_crc_mode_decode (
      .mode          (next_st.cmpctl[2:0]),
      .pin2_dir      (next_st.pindir[BIT_PIN2]),
      .comparator_on (dec_on),
      .use_reference (dec_ref),
      .pin2_output   (dec_pin2),
      .pin2_oe       (dec_oe)
   );

   assign addr8  = paddr[9:2];
   assign setup  = psel && !penable;
   assign access = psel && penable && st.ready;
   assign is_cmp = access && (addr8 == OFS_CMPCTL);
   // a disabled comparator holds its output low
   assign live   = st.actl.comparator_on && (analog_compare ^ st.cmpctl[BIT_INVERT]);

   always_comb
   begin
      port_rd = {2'h0, port_pins_in};
      // pins 0,1,2,4 follow the analog select bits 0..3
      port_rd[0] = port_pins_in[0] && !st.ansel[0];
      port_rd[1] = port_pins_in[1] && !st.ansel[1];
      port_rd[2] = port_pins_in[2] && !st.ansel[2];
      port_rd[4] = port_pins_in[4] && !st.ansel[3];
      if (st.cmpctl[2:0] == MODE_RESET)
      begin
         port_rd[1:0] = 2'h0;
      end
      case (addr8)
         OFS_INTCTL: rd8 = st.intctl;
         OFS_PFLAG:  rd8 = st.pflag & 8'h08;
         OFS_CMPCTL: rd8 = (st.cmpctl & CMP_MASK) | {1'b0, st.result, 6'h00};
         OFS_PINDIR: rd8 = st.pindir & RST_PINDIR;
         OFS_PENA:   rd8 = st.pena & 8'h08;
         OFS_REFCTL: rd8 = st.refctl & REF_MASK;
         OFS_ANSEL:  rd8 = st.ansel & 8'h7f;
         OFS_PORT:   rd8 = port_rd;
         default:    rd8 = 8'h00;
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      // the analog result is asynchronous: two-stage synchroniser
      next_st.result_sync = live;
      next_st.result = st.result_sync;
      // read word and error are formed at setup so that they stand beside pready
      if (setup)
      begin
         next_st.ready = 1'b1;
         next_st.rdata = {24'h0, rd8};
         next_st.err   = !(addr8 inside {OFS_INTCTL, OFS_PFLAG, OFS_CMPCTL, OFS_PINDIR,
                                         OFS_PENA, OFS_REFCTL, OFS_ANSEL, OFS_PORT});
      end
      if (access && pwrite)
      begin
         case (addr8)
            OFS_INTCTL: next_st.intctl = pwdata[7:0];
            OFS_PFLAG:  next_st.pflag = pwdata[7:0] & 8'h08;
            OFS_CMPCTL: next_st.cmpctl = pwdata[7:0] & CMP_MASK;
            OFS_PINDIR: next_st.pindir = pwdata[7:0] & RST_PINDIR;
            OFS_PENA:   next_st.pena = pwdata[7:0] & 8'h08;
            OFS_REFCTL: next_st.refctl = pwdata[7:0] & REF_MASK;
            OFS_ANSEL:  next_st.ansel = pwdata[7:0] & 8'h7f;
            // port pins and unmapped words ignore writes
            default:    next_st.ansel = st.ansel;
         endcase
      end
      // any control access ends the mismatch by re-latching
      if (is_cmp)
      begin
         // the word read was formed a cycle earlier: a change in between is missed
         next_st.latched = st.result;
      end
      // a change coinciding with a control read is dropped, as the silicon may
      else if (st.result != st.latched)
      begin
         next_st.pflag[BIT_CHG] = 1'b1;
      end
      next_st.irq = next_st.pflag[BIT_CHG] && next_st.pena[BIT_CHG]
                    && next_st.intctl[BIT_PERIPH_EN] && next_st.intctl[BIT_GLOBAL_EN];
      // wake needs no global enable; comparator must be running in sleep
      next_st.wake = sleep_active && next_st.actl.comparator_on
                     && next_st.pflag[BIT_CHG] && next_st.pena[BIT_CHG]
                     && next_st.intctl[BIT_PERIPH_EN];
      // sleep itself changes nothing: enabled blocks keep running
      next_st.actl.mode          = next_st.cmpctl[2:0];
      next_st.actl.input_switch  = next_st.cmpctl[BIT_INSW];
      next_st.actl.invert        = next_st.cmpctl[BIT_INVERT];
      next_st.actl.ref_enable    = next_st.refctl[BIT_REFEN];
      next_st.actl.ref_range_low = next_st.refctl[BIT_RANGE];
      next_st.actl.ref_level     = next_st.refctl[3:0];
      next_st.actl.comparator_on = dec_on;
      next_st.actl.use_reference = dec_ref;
      next_st.actl.pin2_output   = dec_pin2;
      next_st.actl.pin2_oe       = dec_oe;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st        <= '0;
         st.pindir <= RST_PINDIR;
         st.ansel  <= RST_ANSEL;
         st.cmpctl <= RST_ZERO;
         st.refctl <= RST_ZERO;
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   // pin two itself is driven by the analog side from analog_ctl, unclocked
   assign prdata                = st.rdata;
   assign pready                = st.ready;
   assign pslverr               = st.err;
   assign analog_ctl            = st.actl;
   assign comparator_result_bit = st.result;
   assign irq_request           = st.irq;
   assign wake_request          = st.wake;
endmodule : crc_top
`default_nettype wire

// >>> verification/crc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module crc_top_monitor
   import crc_pkg::*;
(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 clk_en,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 analog_compare,
   input wire crc_pkg::crc_analog_s analog_ctl,
   input wire logic                 comparator_result_bit,
   input wire logic                 irq_request,
   input wire logic                 wake_request
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   setup_answer_a:
      assert property (psel && !penable && clk_en |=> pready)
         else $error("no pready after setup");
   ready_pulse_a:
      assert property (pready && clk_en |=> !pready) else $error("pready held too long");
   error_ready_a:
      assert property (pslverr |-> pready) else $error("pslverr without pready");
   pin2_modes_a:
      assert property (analog_ctl.pin2_output == (analog_ctl.mode inside {3'h1, 3'h3, 3'h5}))
         else $error("pin two output mode wrong");
   pin2_enable_a:
      assert property (analog_ctl.pin2_oe |-> analog_ctl.pin2_output) else $error("pin two oe");
   ladder_modes_a:
      assert property (analog_ctl.use_reference == (analog_ctl.mode inside {3'h2, 3'h3, 3'h4, 3'h6}))
         else $error("ladder mode wrong");
   reset_state_a:
      assert property ($rose(presetn) |-> analog_ctl.mode == 3'h0 && !analog_ctl.ref_enable)
         else $error("reset state wrong");
   // two edges of pipeline, so four quiet samples are enough to settle the result
   result_follow_a:
      assert property ((clk_en && analog_ctl.comparator_on && $stable(analog_compare)
         && $stable(analog_ctl))[*4]
         |-> comparator_result_bit == (analog_compare ^ analog_ctl.invert)) else $error("result");
   cover property (irq_request);
   cover property (analog_ctl.pin2_oe);
   cover property (wake_request);
   cover property (pslverr);
endmodule : crc_top_monitor
bind crc_top crc_top_monitor u_crc_top_monitor (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .analog_compare(analog_compare),
   .analog_ctl(analog_ctl), .comparator_result_bit(comparator_result_bit),
   .irq_request(irq_request), .wake_request(wake_request));
`default_nettype wire

// >>> verification/crc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module crc_analog_model
   import crc_pkg::*;
#(
   parameter int VDD_MV = 5000
)
(
   input wire crc_pkg::crc_analog_s ctl,
   input wire logic [15:0]          vin_mv,
   output logic                     cmp_out
);
   int ref_mv;
   // sleep is not an input: an enabled comparator keeps running
   always_comb
   begin
      if (!ctl.ref_enable)
         ref_mv = 0;
      else if (ctl.ref_range_low)
         ref_mv = int'(ctl.ref_level) * VDD_MV / 24;
      else
         ref_mv = VDD_MV / 4 + int'(ctl.ref_level) * VDD_MV / 32;
      cmp_out = ctl.comparator_on && (int'(vin_mv) > (ctl.use_reference ? ref_mv : VDD_MV / 2));
   end
endmodule : crc_analog_model
`default_nettype wire

// >>> verification/crc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crc_top_tb;
   import crc_pkg::*;
   typedef struct packed {
      logic       wr;
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] msk;
      logic [7:0] exp;
      logic       err;
   } crc_row_s;
   logic        pclk, pready, pslverr, cmp, res, irq, wake, er;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_active = 1'b0;
   logic        clk_en = 1'b1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [15:0] vin_mv = 16'd3000;
   logic [7:0]  rd;
   crc_analog_s actl;
   int          fail_count = 0, n_tests = 0;
   crc_row_s    rows [9] = '{
      '{1'b0, OFS_CMPCTL, 8'h00, 8'hbf, 8'h00, 1'b0},
      '{1'b0, OFS_REFCTL, 8'h00, 8'hff, 8'h00, 1'b0},
      '{1'b0, OFS_PINDIR, 8'h00, 8'hff, 8'h3f, 1'b0},
      '{1'b0, OFS_PORT, 8'h00, 8'h3f, 8'h28, 1'b0},
      '{1'b1, OFS_REFCTL, 8'hff, 8'hff, 8'haf, 1'b0},
      '{1'b1, OFS_CMPCTL, 8'hff, 8'hbf, 8'h1f, 1'b0},
      '{1'b1, OFS_PENA, 8'h08, 8'h08, 8'h08, 1'b0},
      '{1'b1, OFS_INTCTL, 8'hc0, 8'hc0, 8'hc0, 1'b0},
      '{1'b1, 8'h40, 8'h5a, 8'hff, 8'h00, 1'b1}};
   crc_top u_crc_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .analog_compare(cmp), .port_pins_in(6'h3f),
      .sleep_active(sleep_active), .analog_ctl(actl), .comparator_result_bit(res),
      .irq_request(irq), .wake_request(wake));
   crc_analog_model u_crc_analog_model (.ctl(actl), .vin_mv(vin_mv), .cmp_out(cmp));
   task automatic stop_test();
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 16 && pready !== 1'b1; n++)
         @(posedge pclk);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         stop_test();
      end
   endtask : apb
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].wr)
            apb(1'b1, rows[i].idx, rows[i].wd);
         apb(1'b0, rows[i].idx, 8'h00);
         chk(rd & rows[i].msk, rows[i].exp);
         chk({7'h0, er}, {7'h0, rows[i].err});
      end
      apb(1'b1, OFS_REFCTL, 8'hac);
      apb(1'b1, OFS_CMPCTL, 8'h02);
      repeat (8) @(posedge pclk);
      apb(1'b0, OFS_CMPCTL, 8'h00);
      chk(rd, 8'h42);
      apb(1'b1, OFS_PFLAG, 8'h00);
      apb(1'b0, OFS_PFLAG, 8'h00);
      chk(rd & 8'h08, 8'h00);
      vin_mv <= 16'd1000;
      repeat (8) @(posedge pclk);
      chk({7'h0, irq}, 8'h01);
      apb(1'b1, OFS_PFLAG, 8'h00);
      apb(1'b0, OFS_PFLAG, 8'h00);
      chk(rd & 8'h08, 8'h08);
      apb(1'b0, OFS_CMPCTL, 8'h00);
      chk(rd, 8'h02);
      apb(1'b1, OFS_PFLAG, 8'h00);
      apb(1'b0, OFS_PFLAG, 8'h00);
      chk(rd & 8'h08, 8'h00);
      apb(1'b1, OFS_PFLAG, 8'h08);
      repeat (2) @(posedge pclk);
      chk({7'h0, irq}, 8'h01);
      apb(1'b1, OFS_PFLAG, 8'h00);
      apb(1'b1, OFS_INTCTL, 8'h40);
      sleep_active <= 1'b1;
      apb(1'b1, OFS_CMPCTL, 8'h12);
      repeat (8) @(posedge pclk);
      chk({6'h0, irq, wake}, 8'h01);
      chk({6'h0, actl.comparator_on, actl.ref_enable}, 8'h03);
      apb(1'b0, OFS_CMPCTL, 8'h00);
      chk(rd, 8'h52);
      // clock enable low: the result must hold until the enable returns
      clk_en <= 1'b0;
      vin_mv <= 16'd3000;
      repeat (4) @(posedge pclk);
      chk({7'h0, res}, 8'h01);
      clk_en <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({7'h0, res}, 8'h00);
      // high range: level 4 sits below 1900 mV, level 5 above
      apb(1'b1, OFS_REFCTL, 8'h84);
      vin_mv <= 16'd1900;
      apb(1'b1, OFS_PINDIR, 8'h3b);
      apb(1'b1, OFS_CMPCTL, 8'h03);
      @(posedge pclk);
      chk({5'h0, actl.pin2_output, actl.pin2_oe, actl.use_reference}, 8'h07);
      repeat (4) @(posedge pclk);
      chk({7'h0, res}, 8'h01);
      apb(1'b1, OFS_REFCTL, 8'h85);
      repeat (4) @(posedge pclk);
      chk({7'h0, res}, 8'h00);
      apb(1'b1, OFS_CMPCTL, 8'h05);
      @(posedge pclk);
      chk({5'h0, actl.pin2_output, actl.pin2_oe, actl.use_reference}, 8'h06);
      apb(1'b1, OFS_PINDIR, 8'h3f);
      @(posedge pclk);
      chk({5'h0, actl.pin2_output, actl.pin2_oe, actl.use_reference}, 8'h04);
      apb(1'b1, OFS_CMPCTL, 8'h07);
      apb(1'b1, OFS_REFCTL, 8'h00);
      @(posedge pclk);
      chk({5'h0, wake, actl.comparator_on, actl.ref_enable}, 8'h00);
      // second reset in mid-run, while asleep
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CMPCTL, 8'h00);
      chk(rd, 8'h00);
      apb(1'b0, OFS_REFCTL, 8'h00);
      chk(rd, 8'h00);
      chk({6'h0, irq, wake}, 8'h00);
      stop_test();
   end
endmodule : crc_top_tb
`default_nettype wire
